// *** fsw_status_protect.sv ***
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Complement 1, low guard zero: all protected
// - Complement 1, guard 4,3=00: lower fractions
// - Complement 1, guard 4,3=01: upper fractions
// - Complement 1, guard two,one set: none
// - Complement 1, guard 4,3=10: all but top
// - Complement 1, guard 4,3=11: all but bottom
// - Low byte: mode0, guard, latch, busy
// - High byte: suspends, complement, locks, quad, mode1
// - Lock bits are one-time programmable
// - Busy flag high during program, erase, write
// - Latch clear refuses writes, programs, erases
// - Guard bits change only by unprotected write
// - Reject program/erase targeting protected region
// - Chip erase only for listed guard codes
// - Mode 00: writable once latch set
// - Mode 01, pin low: status locked
// - Mode 01, pin high: writable after latch
// - Mode 10: locked until power cycle
// - Mode 11: status writes refused forever
// - Power cycle turns mode 10 into 00
// - Latch set by enable, cleared by writes
// - Complement 1 selects the inverse regions
// - Suspend sets flags; resume, reset clear
module fsw_status_protect
  import fsw_pkg::*;
#(
  parameter int unsigned CNT_W        = 32,
  parameter int unsigned SR_WRITE_CYC = 32'((64'(`FSW_T_SR_WRITE_US) * 64'd1000) / 64'(`FSW_CLK_PERIOD_NS)),
  parameter int unsigned PROG_CYC     = 32'((64'(`FSW_T_PAGE_PROG_US) * 64'd1000) / 64'(`FSW_CLK_PERIOD_NS)),
  parameter int unsigned SECT_CYC     = 32'((64'(`FSW_T_SECT_ERASE_US) * 64'd1000) / 64'(`FSW_CLK_PERIOD_NS)),
  parameter int unsigned BLK_CYC      = 32'((64'(`FSW_T_BLK_ERASE_US) * 64'd1000) / 64'(`FSW_CLK_PERIOD_NS)),
  parameter int unsigned CHIP_CYC     = 32'((64'(`FSW_T_CHIP_ERASE_US) * 64'd1000) / 64'(`FSW_CLK_PERIOD_NS))
) (
  // Clock and power-on reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Decoded command from the serial front end
  input  wire fsw_req_t    req,
  // Write-protect pin and stored nonvolatile image
  input  wire logic        writeProtectN,
  input  wire logic [15:0] nvImage,
  // Status and outcome
  output var fsw_status_t  status,
  output logic             cmdAccepted,
  output logic             cmdRefused,
  output logic             opDone
);
  if (CNT_W < 8 || CNT_W > 32 || SR_WRITE_CYC == 0 || PROG_CYC == 0 || SECT_CYC == 0
      || BLK_CYC == 0 || CHIP_CYC == 0) begin : g_bad_params
    $error("fsw_status_protect: counter width or cycle count out of range");
  end
  if (CNT_W < 32 && (CHIP_CYC >= (64'd1 << CNT_W) || BLK_CYC >= (64'd1 << CNT_W)
      || SECT_CYC >= (64'd1 << CNT_W) || PROG_CYC >= (64'd1 << CNT_W)
      || SR_WRITE_CYC >= (64'd1 << CNT_W))) begin : g_too_long
    $error("fsw_status_protect: cycle count does not fit the counter");
  end

  fsw_state_t  state_ff;
  fsw_state_t  nxt_state;
  fsw_status_t status_ff;
  fsw_status_t nxt_status;
  // Written word parks here until the status write completes
  fsw_status_t pend_ff;
  fsw_status_t nxt_pend;
  fsw_op_t     kind_ff;
  fsw_op_t     nxt_kind;
  logic        loaded_ff;
  logic        nxt_loaded;
  logic        arm_ff;
  logic        nxt_arm;
  logic        accepted_ff;
  logic        nxt_accepted;
  logic        refused_ff;
  logic        nxt_refused;
  logic        done_ff;
  logic        nxt_done;

  logic                   tmrLoad;
  logic [CNT_W-1:0]       tmrVal;
  logic                   tmrAbort;
  logic                   tmrDone;
  logic                   tmrRun;
  logic [`FSW_SECT_W-1:0] tgtLo;
  logic [`FSW_SECT_W-1:0] tgtHi;
  logic                   hit;
  logic                   chipOk;
  logic                   srWritable;
  logic                   swReset;
  logic                   isProgram;
  logic                   isErase;
  logic                   isChip;

  fsw_guard_decode u_guard (
    .arrayGuard       (status_ff.arrayGuard),
    .complementSelect (status_ff.complementSelect),
    .tgtLo            (tgtLo),
    .tgtHi            (tgtHi),
    .hit              (hit),
    .chipOk           (chipOk)
  );

  fsw_op_timer #(
    .CNT_W (CNT_W)
  ) u_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .load    (tmrLoad),
    .loadVal (tmrVal),
    .run     (tmrRun),
    .abort   (tmrAbort),
    .done    (tmrDone)
  );

  // Timer follows the next state: a suspend taken as the count reaches one
  // then holds the count instead of firing a completion that nobody sees
  always_comb begin
    tmrRun = (nxt_state == ST_BUSY);
  end

  // Sector span touched by an address command
  always_comb begin
    tgtLo = req.addr[20:12];
    tgtHi = req.addr[20:12];
    if (req.code == CMD_BLOCK_ERASE32) begin
      tgtLo = {req.addr[20:15], 3'h0};
      tgtHi = {req.addr[20:15], 3'h7};
    end else if (req.code == CMD_BLOCK_ERASE64) begin
      tgtLo = {req.addr[20:16], 4'h0};
      tgtHi = {req.addr[20:16], 4'hF};
    end
  end

  always_comb begin
    isProgram = (req.code == CMD_PAGE_PROGRAM) || (req.code == CMD_QUAD_PROGRAM);
    isErase   = (req.code == CMD_SECTOR_ERASE) || (req.code == CMD_BLOCK_ERASE32)
             || (req.code == CMD_BLOCK_ERASE64);
    isChip    = (req.code == CMD_CHIP_ERASE_A) || (req.code == CMD_CHIP_ERASE_B);
    // Mode 00 ignores the pin; 10 and 11 never allow a write
    unique case ({status_ff.protectModeBitOne, status_ff.protectModeBitZero})
      2'b00:   srWritable = 1'b1;
      2'b01:   srWritable = writeProtectN;
      2'b10:   srWritable = 1'b0;
      default: srWritable = 1'b0;
    endcase
  end

  always_comb begin
    nxt_state    = state_ff;
    nxt_status   = status_ff;
    nxt_pend     = pend_ff;
    nxt_kind     = kind_ff;
    nxt_arm      = arm_ff;
    nxt_accepted = 1'b0;
    nxt_refused  = 1'b0;
    tmrLoad      = 1'b0;
    tmrVal       = CNT_W'(SR_WRITE_CYC);
    tmrAbort     = 1'b0;
    swReset      = 1'b0;
    nxt_loaded   = 1'b1;
    nxt_done     = 1'b0;
    if (!loaded_ff) begin
      // Bring back the stored bits once, right after power-up
      nxt_status = fsw_status_t'(nvImage & `FSW_NV_MASK);
      if (nvImage[8] && !nvImage[7]) begin
        nxt_status.protectModeBitOne = 1'b0;
      end
      nxt_refused = req.valid;
    end else begin
      if (req.valid) begin
        nxt_arm = (req.code == CMD_RESET_ENABLE);
      end
      swReset = req.valid && arm_ff && (req.code == CMD_RESET);
      if (swReset) begin
        // Aborts any operation, clears only volatile state
        nxt_accepted                    = 1'b1;
        nxt_state                       = ST_IDLE;
        tmrAbort                        = 1'b1;
        nxt_status.writeLatch           = 1'b0;
        nxt_status.eraseSuspendedFlag   = 1'b0;
        nxt_status.programSuspendedFlag = 1'b0;
      end else if (req.valid) begin
        nxt_refused = 1'b1;
        unique case (state_ff)
          ST_IDLE: begin
            if (req.code == CMD_WRITE_ENABLE) begin
              nxt_status.writeLatch = 1'b1;
              nxt_refused           = 1'b0;
            end else if (req.code == CMD_WRITE_DISABLE || req.code == CMD_RESET_ENABLE) begin
              nxt_status.writeLatch = (req.code == CMD_RESET_ENABLE) && status_ff.writeLatch;
              nxt_refused           = 1'b0;
            end else if (req.code == CMD_STATUS_WRITE && status_ff.writeLatch && srWritable) begin
              nxt_pend = fsw_status_t'(req.data);
              nxt_kind = OP_STATUS;
              tmrVal   = CNT_W'(SR_WRITE_CYC);
              tmrLoad  = 1'b1;
              nxt_refused = 1'b0;
            end else if (isProgram && status_ff.writeLatch && !hit) begin
              nxt_kind    = OP_PROG;
              tmrVal      = CNT_W'(PROG_CYC);
              tmrLoad     = 1'b1;
              nxt_refused = 1'b0;
            end else if (isErase && status_ff.writeLatch && !hit) begin
              nxt_kind    = (req.code == CMD_SECTOR_ERASE) ? OP_SECT
                          : (req.code == CMD_BLOCK_ERASE32) ? OP_BLK32 : OP_BLK64;
              tmrVal      = (req.code == CMD_SECTOR_ERASE) ? CNT_W'(SECT_CYC) : CNT_W'(BLK_CYC);
              tmrLoad     = 1'b1;
              nxt_refused = 1'b0;
            end else if (isChip && status_ff.writeLatch && chipOk) begin
              nxt_kind    = OP_CHIP;
              tmrVal      = CNT_W'(CHIP_CYC);
              tmrLoad     = 1'b1;
              nxt_refused = 1'b0;
            end
            if (tmrLoad) begin
              nxt_state             = ST_BUSY;
              nxt_status.writeLatch = 1'b0;
            end
          end
          ST_BUSY: begin
            // Status writes and chip erase cannot be suspended
            // In the completion cycle the result is already due, so no suspend
            if (req.code == CMD_SUSPEND && !tmrDone && kind_ff != OP_STATUS && kind_ff != OP_CHIP) begin
              nxt_state   = ST_SUSP;
              nxt_refused = 1'b0;
              if (kind_ff == OP_PROG) begin
                nxt_status.programSuspendedFlag = 1'b1;
              end else begin
                nxt_status.eraseSuspendedFlag = 1'b1;
              end
            end else if (req.code == CMD_RESET_ENABLE) begin
              nxt_refused = 1'b0;
            end
          end
          ST_SUSP: begin
            if (req.code == CMD_RESUME) begin
              nxt_state                       = ST_BUSY;
              nxt_status.eraseSuspendedFlag   = 1'b0;
              nxt_status.programSuspendedFlag = 1'b0;
              nxt_refused                     = 1'b0;
            end else if (req.code == CMD_WRITE_ENABLE) begin
              nxt_status.writeLatch = 1'b1;
              nxt_refused           = 1'b0;
            end else if (req.code == CMD_WRITE_DISABLE || req.code == CMD_RESET_ENABLE) begin
              nxt_status.writeLatch = (req.code == CMD_RESET_ENABLE) && status_ff.writeLatch;
              nxt_refused           = 1'b0;
            end
          end
          default: begin
            nxt_state = ST_IDLE;
          end
        endcase
        nxt_accepted = !nxt_refused;
      end
      if (tmrDone && state_ff == ST_BUSY && !swReset) begin
        nxt_state = ST_IDLE;
        nxt_done  = 1'b1;
        if (kind_ff == OP_STATUS) begin
          // Read-only bits keep their own values
          nxt_status.protectModeBitZero = pend_ff.protectModeBitZero;
          nxt_status.arrayGuard         = pend_ff.arrayGuard;
          nxt_status.complementSelect   = pend_ff.complementSelect;
          nxt_status.quadEnable         = pend_ff.quadEnable;
          nxt_status.protectModeBitOne  = pend_ff.protectModeBitOne;
          nxt_status.secureLock         = status_ff.secureLock | pend_ff.secureLock;
        end
      end
    end
    nxt_status.busyFlag = (nxt_state == ST_BUSY);
  end

  // Pulses last one cycle; status holds until the next change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= ST_IDLE;
      status_ff   <= fsw_status_t'(`FSW_STATUS_RESET);
      pend_ff     <= fsw_status_t'(`FSW_STATUS_RESET);
      kind_ff     <= OP_STATUS;
      loaded_ff   <= 1'b0;
      arm_ff      <= 1'b0;
      accepted_ff <= 1'b0;
      refused_ff  <= 1'b0;
      done_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      status_ff   <= nxt_status;
      pend_ff     <= nxt_pend;
      kind_ff     <= nxt_kind;
      loaded_ff   <= nxt_loaded;
      arm_ff      <= nxt_arm;
      accepted_ff <= nxt_accepted;
      refused_ff  <= nxt_refused;
      done_ff     <= nxt_done;
    end
  end

  // Bit order of the struct is the status word layout
  assign status      = status_ff;
  assign cmdAccepted = accepted_ff;
  assign cmdRefused  = refused_ff;
  assign opDone      = done_ff;
endmodule
`default_nettype wire

// *** fsw_consts.svh ***
`ifndef FSW_CONSTS_SVH
`define FSW_CONSTS_SVH

// Clock
`define FSW_CLK_PERIOD_NS      20

// Operation times in microseconds; the device is free to choose them
`define FSW_T_SR_WRITE_US      2000
`define FSW_T_PAGE_PROG_US     1000
`define FSW_T_SECT_ERASE_US    100000
`define FSW_T_BLK_ERASE_US     500000
`define FSW_T_CHIP_ERASE_US    10000000

// Array geometry
`define FSW_ADDR_W             21
`define FSW_SECT_W             9
`define FSW_SECT_LAST          10'd511
`define FSW_SECT_COUNT         10'd512
`define FSW_SECTS_PER_BLK64    10'd16

// Status word: reset value and the nonvolatile bits
`define FSW_STATUS_RESET       16'h0000
`define FSW_NV_MASK            16'h7BFC

// Command opcodes
`define FSW_OP_WRITE_ENABLE_CMD            8'h06
`define FSW_OP_WRITE_DISABLE_CMD            8'h04
`define FSW_OP_STATUS_WRITE_CMD            8'h01
`define FSW_OP_PP              8'h02
`define FSW_OP_QPP             8'h32
`define FSW_OP_SE              8'h20
`define FSW_OP_BE32            8'h52
`define FSW_OP_BE64            8'hD8
`define FSW_OP_CE_A            8'h60
`define FSW_OP_CE_B            8'hC7
`define FSW_OP_SUSPEND         8'h75
`define FSW_OP_RESUME          8'h7A
`define FSW_OP_RST_EN          8'h66
`define FSW_OP_RST             8'h99

`endif

// *** fsw_pkg.sv ***
package fsw_pkg;
  `include "fsw_consts.svh"

  typedef enum logic [7:0] {
    CMD_WRITE_ENABLE  = `FSW_OP_WRITE_ENABLE_CMD,
    CMD_WRITE_DISABLE = `FSW_OP_WRITE_DISABLE_CMD,
    CMD_STATUS_WRITE  = `FSW_OP_STATUS_WRITE_CMD,
    CMD_PAGE_PROGRAM  = `FSW_OP_PP,
    CMD_QUAD_PROGRAM  = `FSW_OP_QPP,
    CMD_SECTOR_ERASE  = `FSW_OP_SE,
    CMD_BLOCK_ERASE32 = `FSW_OP_BE32,
    CMD_BLOCK_ERASE64 = `FSW_OP_BE64,
    CMD_CHIP_ERASE_A  = `FSW_OP_CE_A,
    CMD_CHIP_ERASE_B  = `FSW_OP_CE_B,
    CMD_SUSPEND       = `FSW_OP_SUSPEND,
    CMD_RESUME        = `FSW_OP_RESUME,
    CMD_RESET_ENABLE  = `FSW_OP_RST_EN,
    CMD_RESET         = `FSW_OP_RST
  } fsw_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_SUSP = 3'b100
  } fsw_state_t;

  typedef enum logic [2:0] {
    OP_STATUS = 3'h0,
    OP_PROG   = 3'h1,
    OP_SECT   = 3'h2,
    OP_BLK32  = 3'h3,
    OP_BLK64  = 3'h4,
    OP_CHIP   = 3'h5
  } fsw_op_t;

  typedef struct packed {
    logic                   valid;
    logic [7:0]             code;
    logic [`FSW_ADDR_W-1:0] addr;
    logic [15:0]            data;
  } fsw_req_t;

  typedef struct packed {
    logic       eraseSuspendedFlag;
    logic       complementSelect;
    logic [2:0] secureLock;
    logic       programSuspendedFlag;
    logic       quadEnable;
    logic       protectModeBitOne;
    logic       protectModeBitZero;
    logic [4:0] arrayGuard;
    logic       writeLatch;
    logic       busyFlag;
  } fsw_status_t;
endpackage

// *** fsw_guard_decode.sv ***
`timescale 1ns/100ps
`default_nettype none
module fsw_guard_decode
  import fsw_pkg::*;
(
  // Protection settings
  input  wire logic [4:0]             arrayGuard,
  input  wire logic                   complementSelect,
  // Sector span of the target
  input  wire logic [`FSW_SECT_W-1:0] tgtLo,
  input  wire logic [`FSW_SECT_W-1:0] tgtHi,
  // Verdicts
  output logic                        hit,
  output logic                        chipOk
);
  logic [9:0] regLo;
  logic [9:0] regHi;
  logic [9:0] size;
  logic       regNone;
  logic [9:0] lo10;
  logic [9:0] hi10;

  // Region for complement 0; complement 1 protects its inverse
  always_comb begin
    regLo   = 10'h000;
    regHi   = `FSW_SECT_LAST;
    size    = 10'h000;
    regNone = 1'b0;
    lo10    = {1'b0, tgtLo};
    hi10    = {1'b0, tgtHi};
    if (arrayGuard[2:0] == 3'h0) begin
      regNone = 1'b1;
    end else if (arrayGuard[2:1] == 2'h3) begin
      regNone = 1'b0;
    end else begin
      if (!arrayGuard[4]) begin
        size = `FSW_SECTS_PER_BLK64 << (arrayGuard[2:0] - 3'h1);
      end else if (arrayGuard[2]) begin
        size = 10'h008;
      end else begin
        size = 10'h001 << (arrayGuard[1:0] - 2'h1);
      end
      if (arrayGuard[3]) begin
        regHi = size - 10'h001;
      end else begin
        regLo = `FSW_SECT_COUNT - size;
      end
    end
    if (complementSelect) begin
      hit = regNone || (lo10 < regLo) || (hi10 > regHi);
    end else begin
      hit = !regNone && (lo10 <= regHi) && (hi10 >= regLo);
    end
    chipOk = (arrayGuard[2:0] == 3'h0 && !complementSelect)
          || (arrayGuard[2:0] == 3'h7 && complementSelect);
  end
endmodule
`default_nettype wire

// *** fsw_op_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module fsw_op_timer #(
  parameter int unsigned CNT_W = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] loadVal,
  input  wire logic             run,
  input  wire logic             abort,
  // Completion
  output logic                  done
);
  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] nxt_count;
  logic             done_ff;
  logic             nxt_done;

  // Holding the count while run is low is what makes suspend resumable
  always_comb begin
    nxt_count = count_ff;
    nxt_done  = 1'b0;
    if (abort) begin
      nxt_count = '0;
    end else if (load) begin
      nxt_count = loadVal;
    end else if (run && count_ff != '0) begin
      nxt_count = count_ff - 1'b1;
      nxt_done  = (count_ff == CNT_W'(1));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= '0;
      done_ff  <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      done_ff  <= nxt_done;
    end
  end

  assign done = done_ff;
endmodule
`default_nettype wire

// *** fsw_status_protect_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module fsw_status_protect_asserts
  import fsw_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Block inputs
  input  wire fsw_req_t    req,
  input  wire logic        writeProtectN,
  input  wire logic [15:0] nvImage,
  // Block outputs
  input  wire fsw_status_t status,
  input  wire logic        cmdAccepted,
  input  wire logic        cmdRefused,
  input  wire logic        opDone
);
  logic live_ff;
  logic nxt_live;

  // High from the first edge after reset; with its past value it masks the nonvolatile load
  always_comb nxt_live = 1'b1;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      live_ff <= 1'b0;
    else
      live_ff <= nxt_live;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_taken(logic [7:0] op);
    req.valid && req.code == op ##1 cmdAccepted;
  endsequence

  sequence s_sr_req;
    req.valid && req.code == 8'h01;
  endsequence

  a_latch_gate: assert property (req.valid && !status.writeLatch &&
      req.code inside {8'h01, 8'h02, 8'h32, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7} |=> cmdRefused)
    else $error("Write-class command taken with latch clear");
  a_hw_lock: assert property (s_sr_req ##0 !writeProtectN &&
      !status.protectModeBitOne && status.protectModeBitZero |=> cmdRefused)
    else $error("Status write taken under pin lock");
  a_mode_lock: assert property (s_sr_req ##0 status.protectModeBitOne |=> cmdRefused)
    else $error("Status write taken in locked mode");
  a_sr_start: assert property (s_taken(8'h01) |-> status.busyFlag && !status.writeLatch)
    else $error("Status write start wrong");
  a_enable_sets: assert property (s_taken(8'h06) |-> status.writeLatch)
    else $error("Write enable did not set latch");
  a_disable_clr: assert property (s_taken(8'h04) |-> !status.writeLatch)
    else $error("Write disable did not clear latch");
  a_lock_sticky: assert property ((status.secureLock & $past(status.secureLock)) == $past(status.secureLock))
    else $error("Lock bit cleared");
  a_guard_quiet: assert property (live_ff && $past(live_ff) && $changed(status.arrayGuard) |-> opDone)
    else $error("Guard bits changed outside a status write");
  a_chip_gate: assert property (req.valid && (req.code == 8'h60 || req.code == 8'hC7) &&
      !(status.arrayGuard[2:0] == 3'h0 && !status.complementSelect) &&
      !(status.arrayGuard[2:0] == 3'h7 && status.complementSelect) |=> cmdRefused)
    else $error("Chip erase taken with wrong guard code");
  a_suspend_flags: assert property (s_taken(8'h75) |-> !status.busyFlag &&
      (status.eraseSuspendedFlag || status.programSuspendedFlag))
    else $error("Suspend flags wrong");
  a_resume_flags: assert property (s_taken(8'h7A) |-> status.busyFlag &&
      !status.eraseSuspendedFlag && !status.programSuspendedFlag)
    else $error("Resume flags wrong");
  a_done_idle: assert property (opDone |-> !status.busyFlag ##1 !opDone)
    else $error("Completion while busy");
  a_power_load: assert property (live_ff && !$past(live_ff) |->
      status.arrayGuard == nvImage[6:2] && status.protectModeBitOne == (nvImage[8] && nvImage[7])
      && !status.busyFlag && !status.writeLatch)
    else $error("Power-up load wrong");
endmodule

bind fsw_status_protect fsw_status_protect_asserts chk_u (
  .clk(clk), .rst_n(rst_n), .req(req), .writeProtectN(writeProtectN), .nvImage(nvImage),
  .status(status), .cmdAccepted(cmdAccepted), .cmdRefused(cmdRefused), .opDone(opDone)
);
`default_nettype wire

// *** fsw_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module fsw_host_model
  import fsw_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Command out
  output var fsw_req_t req
);
  initial req = '0;

  // One-cycle strobe; payload inverted after so stale values never match
  task automatic send(input logic [7:0] code, input logic [20:0] addr, input logic [15:0] data);
    @(posedge clk);
    #1;
    req = '{1'b1, code, addr, data};
    @(posedge clk);
    #1;
    req = '{1'b0, ~code, ~addr, ~data};
  endtask
endmodule
`default_nettype wire

// *** fsw_status_protect_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module fsw_status_protect_tb
  import fsw_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic        writeProtectN;
  logic [15:0] nvImage;
  fsw_req_t    req;
  fsw_status_t st;
  logic        cmdAccepted;
  logic        cmdRefused;
  logic        opDone;
  int          bad_count;
  int          n_checks;
  logic        expQ[$];
  logic [7:0]  gated[8] = '{8'h01, 8'h02, 8'h32, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};

  fsw_host_model host_u (.clk(clk), .req(req));
  fsw_status_protect #(.SR_WRITE_CYC(6), .PROG_CYC(5), .SECT_CYC(8), .BLK_CYC(8), .CHIP_CYC(10)) dut_u (
    .clk(clk), .rst_n(rst_n), .req(req), .writeProtectN(writeProtectN), .nvImage(nvImage),
    .status(st), .cmdAccepted(cmdAccepted), .cmdRefused(cmdRefused), .opDone(opDone));

  always #10 clk = ~clk;

  task automatic fail(input string msg);
    bad_count++;
    $display("BAD t=%0t %s", $time, msg);
  endtask

  task automatic cmp_st(input logic [15:0] exp);
    n_checks++;
    if (st !== exp)
      fail($sformatf("status %h expected %h", st, exp));
  endtask

  task automatic cmp_resp(input logic exp, input logic acc, input logic refd);
    n_checks++;
    if ({acc, refd} !== {exp, ~exp})
      fail($sformatf("answer %b%b expected accept=%b", acc, refd, exp));
  endtask

  task automatic cmd(input logic [7:0] code, input logic [20:0] addr, input logic [15:0] data, input logic exp);
    expQ.push_back(exp);
    host_u.send(code, addr, data);
  endtask

  task automatic wait_done();
    int i;
    for (i = 0; i < 300 && opDone !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (opDone !== 1'b1)
      fail("no completion");
  endtask

  task automatic wr_sr(input logic [15:0] data, input logic exp);
    cmd(8'h06, 21'h000000, 16'h0000, 1'b1);
    cmd(8'h01, 21'h000000, data, exp);
    if (exp)
      wait_done();
  endtask

  // Sector-level offsets are random; block erases ignore them
  task automatic reg_chk(input logic cmp, input logic [4:0] g, input logic [7:0] code, input logic [20:0] a,
                         input logic exp);
    wr_sr({1'b0, cmp, 7'h00, g, 2'b00}, 1'b1);
    cmd(8'h06, 21'h000000, 16'h0000, 1'b1);
    cmd(code, a | (21'($urandom) & 21'h000FFF), 16'h0000, exp);
    if (exp)
      wait_done();
  endtask

  task automatic do_reset(input logic [15:0] img);
    // Let the last answer be checked before reset wipes its pulse
    do
      @(posedge clk);
    while (expQ.size() != 0);
    #1;
    nvImage = img;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(negedge clk) begin
    if (cmdAccepted === 1'b1 || cmdRefused === 1'b1) begin
      if (expQ.size() == 0)
        fail("unexpected answer");
      else
        cmp_resp(expQ.pop_front(), cmdAccepted, cmdRefused);
    end
  end

  // About twenty times the expected run
  initial begin
    #200000;
    fail("watchdog");
    conclude();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    writeProtectN = 1'b1;
    nvImage = 16'h0000;
    bad_count = 0;
    n_checks = 0;
    void'($urandom(32'h41905BCB));
    do_reset(16'h0000);
    cmp_st(16'h0000);
    foreach (gated[i])
      cmd(gated[i], 21'($urandom), 16'($urandom), 1'b0);
    cmd(8'h06, 21'h000000, 16'h0000, 1'b1);
    cmp_st(16'h0002);
    cmd(8'h04, 21'h000000, 16'h0000, 1'b1);
    cmp_st(16'h0000);
    wr_sr(16'h8E07, 1'b1);
    cmp_st(16'h0A04);
    cmd(8'h06, 21'h000000, 16'h0000, 1'b1);
    cmd(8'h20, 21'h1F0000 | (21'($urandom) & 21'h000FFF), 16'h0000, 1'b0);
    cmd(8'h20, 21'h1EF000, 16'h0000, 1'b1);
    cmp_st(16'h0A05);
    wait_done();
    cmp_st(16'h0A04);
    wr_sr(16'h0000, 1'b1);
    cmp_st(16'h0800);
    reg_chk(1'b1, 5'b11000, 8'h20, 21'h000000, 1'b0);
    reg_chk(1'b1, 5'b11000, 8'h60, 21'h000000, 1'b0);
    reg_chk(1'b1, 5'b00001, 8'h20, 21'h1EF000, 1'b0);
    reg_chk(1'b1, 5'b00001, 8'h02, 21'h1F0000, 1'b1);
    reg_chk(1'b1, 5'b01001, 8'h52, 21'h010000, 1'b0);
    reg_chk(1'b1, 5'b01001, 8'h20, 21'h00F000, 1'b1);
    reg_chk(1'b1, 5'b00110, 8'hD8, 21'h1F0000, 1'b1);
    reg_chk(1'b1, 5'b10001, 8'h20, 21'h1FE000, 1'b0);
    reg_chk(1'b1, 5'b10001, 8'h20, 21'h1FF000, 1'b1);
    reg_chk(1'b1, 5'b10101, 8'h02, 21'h1F8000, 1'b1);
    reg_chk(1'b1, 5'b11101, 8'h20, 21'h008000, 1'b0);
    reg_chk(1'b1, 5'b11001, 8'h20, 21'h000000, 1'b1);
    reg_chk(1'b1, 5'b00111, 8'h60, 21'h000000, 1'b1);
    reg_chk(1'b0, 5'b00000, 8'hC7, 21'h000000, 1'b1);
    reg_chk(1'b0, 5'b00110, 8'h20, 21'h000000, 1'b0);
    wr_sr(16'h0080, 1'b1);
    cmp_st(16'h0880);
    writeProtectN = 1'b0;
    wr_sr(16'h0000, 1'b0);
    cmp_st(16'h0882);
    writeProtectN = 1'b1;
    wr_sr(16'h0100, 1'b1);
    cmp_st(16'h0900);
    wr_sr(16'h0000, 1'b0);
    do_reset(16'h0100);
    cmp_st(16'h0000);
    cmd(8'h06, 21'h000000, 16'h0000, 1'b1);
    cmd(8'hD8, 21'h020000, 16'h0000, 1'b1);
    cmd(8'h75, 21'h000000, 16'h0000, 1'b1);
    cmp_st(16'h8000);
    cmd(8'h7A, 21'h000000, 16'h0000, 1'b1);
    cmp_st(16'h0001);
    wait_done();
    cmp_st(16'h0000);
    cmd(8'h06, 21'h000000, 16'h0000, 1'b1);
    cmd(8'h02, 21'h000100, 16'h0000, 1'b1);
    cmd(8'h75, 21'h000000, 16'h0000, 1'b1);
    cmp_st(16'h0400);
    cmd(8'h06, 21'h000000, 16'h0000, 1'b1);
    cmd(8'h66, 21'h000000, 16'h0000, 1'b1);
    cmd(8'h99, 21'h000000, 16'h0000, 1'b1);
    cmp_st(16'h0000);
    do_reset(16'h0180);
    cmp_st(16'h0180);
    wr_sr(16'h0000, 1'b0);
    cmp_st(16'h0182);
    repeat (3) @(negedge clk);
    if (expQ.size() != 0)
      fail("answers missing");
    conclude();
  end
endmodule
`default_nettype wire
